// ### inc/dpm_consts.svh
// Offsets, field positions, reset values, ranges and timing counts of the protection monitor.
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH
`define DPM_OFF_CTRL        8'h00
`define DPM_OFF_OVL_COEF    8'h04
`define DPM_OFF_UV_LEVEL    8'h08
`define DPM_OFF_OV_LEVEL    8'h0c
`define DPM_OFF_DEC_VCOEF   8'h10
`define DPM_OFF_CLIM_LEVEL  8'h14
`define DPM_OFF_ACC_CCOEF   8'h18
`define DPM_OFF_CONST_CCOEF 8'h1c
`define DPM_OFF_DROP_TIME   8'h20
`define DPM_OFF_DROP_LEVEL  8'h24
`define DPM_OFF_PRE_LEVEL   8'h28
`define DPM_OFF_PRE_DELAY   8'h2c
`define DPM_OFF_STATUS      8'h30
`define DPM_OFF_IRQ_STAT    8'h34
`define DPM_OFF_IRQ_MASK    8'h38
`define DPM_CTRL_OVL_LSB    0
`define DPM_CTRL_UV_EN      2
`define DPM_CTRL_FW_SEL     3
`define DPM_CTRL_RST        4'h1
`define DPM_OVL_MIN         16'h00c8
`define DPM_OVL_MAX         16'h04b0
`define DPM_OVL_RST         16'h03e8
`define DPM_UV_LV_MIN       16'h00b4
`define DPM_UV_LV_MAX       16'h0118
`define DPM_UV_LV_RST       16'h00c8
`define DPM_UV_HV_MIN       16'h014a
`define DPM_UV_HV_MAX       16'h01e0
`define DPM_UV_HV_RST       16'h015e
`define DPM_OV_LV_MIN       16'h015e
`define DPM_OV_LV_MAX       16'h0186
`define DPM_OV_LV_RST       16'h0172
`define DPM_OV_HV_MIN       16'h0226
`define DPM_OV_HV_MAX       16'h030c
`define DPM_OV_HV_RST       16'h0294
`define DPM_COEF_MAX        16'h0064
`define DPM_COEF_RST        16'h0032
`define DPM_CLIM_MIN        16'h0050
`define DPM_PCT_MAX         16'h00c8
`define DPM_PCT_G_RST       16'h00a0
`define DPM_PCT_P_RST       16'h0078
`define DPM_PRE_MIN         16'h0014
`define DPM_CONST_MAX       16'h1388
`define DPM_CONST_RST       16'h0028
`define DPM_DROP_T_MIN      16'h0001
`define DPM_DROP_T_MAX      16'h0258
`define DPM_DROP_T_RST      16'h0032
`define DPM_DROP_L_MAX      16'h03e8
`define DPM_PRE_D_MAX       16'h0bb8
`define DPM_PRE_D_RST       16'h0064
`define DPM_LOWSPD_FREQ     32'd3000
`define DPM_FW_FREQ         32'd5000
`define DPM_WARN_PRE        8'h09
`define DPM_TICK_MS         100
`define DPM_CLK_MHZ         200
`define DPM_TICK_CYCLES     (`DPM_TICK_MS * `DPM_CLK_MHZ * 1000)
`endif

// ### inc/dpm_pkg.sv
// Types shared by the protection monitor modules.
package dpm_pkg;
    typedef enum logic [2:0] {
        DPM_ST_ACCEL = 3'b001,
        DPM_ST_CONST = 3'b010,
        DPM_ST_DECEL = 3'b100
    } dpm_motion_e;
    typedef logic [15:0] dpm_word_t;
    typedef logic [5:0]  dpm_evt_t;
endpackage

// ### inc/dpm_timer_if.sv
// Carrier between the monitor and one qualifying timer.
`timescale 1ns/1ps
interface dpm_timer_if;
    logic        cond;
    logic [11:0] limit;
    logic        expired;
    modport ctrl (output cond, output limit, input expired);
    modport tmr  (input cond, input limit, output expired);
endinterface

// ### core/dpm_qual_timer.sv
// Qualifying timer counting tenths of a second while its condition holds.
`timescale 1ns/1ps
module dpm_qual_timer
    import dpm_pkg::*;
#(
    parameter int TICK_CYCLES = 20000000
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ce,
    dpm_timer_if.tmr tif
);
    logic [31:0] preReg;
    logic [11:0] tenthReg;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            preReg   <= 32'h0;
            tenthReg <= 12'h0;
        end else if (ce) begin
            if (!tif.cond) begin
                preReg   <= 32'h0; // [RULE_18]
                tenthReg <= 12'h0; // [RULE_18]
            end else if (tenthReg < tif.limit) begin
                if (preReg == 32'(TICK_CYCLES - 1)) begin
                    preReg   <= 32'h0;
                    tenthReg <= tenthReg + 12'h1;
                end else begin
                    preReg <= preReg + 32'h1;
                end
            end
        end
    end

    assign tif.expired = tif.cond && (tenthReg >= tif.limit);
endmodule // dpm_qual_timer

// ### core/dpm_lim_calc.sv
// Threshold arithmetic for motor overload and current limiting.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_lim_calc
    import dpm_pkg::*;
(
    input  wire logic [1:0]  ovlMode,
    input  wire dpm_word_t   ovlCoef,
    input  wire dpm_word_t   outFreq,
    input  wire dpm_word_t   climPct,
    input  wire logic        fieldWeak,
    output dpm_word_t        ovlThresh,
    output dpm_word_t        climThresh
);
    logic [31:0] ovlWide;
    logic [31:0] climWide;
    logic [31:0] climBase;

    always_comb begin
        ovlWide  = {16'h0, ovlCoef};
        climBase = {16'h0, climPct} * 32'd10;
        climWide = climBase;
        // Below the low-speed corner the threshold falls linearly to half at standstill.
        if (ovlMode == 2'd1 && {16'h0, outFreq} < `DPM_LOWSPD_FREQ) begin
            ovlWide = ({16'h0, ovlCoef} * ({16'h0, outFreq} + `DPM_LOWSPD_FREQ))
                      / (32'd2 * `DPM_LOWSPD_FREQ); // [RULE_01]
        end // [RULE_02]
        if (fieldWeak && {16'h0, outFreq} > `DPM_FW_FREQ) begin
            climWide = (climBase * `DPM_FW_FREQ) / {16'h0, outFreq}; // [RULE_10]
        end
    end

    assign ovlThresh  = ovlWide[15:0];
    assign climThresh = climWide[15:0];
endmodule // dpm_lim_calc

// ### core/dpm_top.sv
// Drive protection and limiting supervisor with its APB register file.
//
// Function
// [RULE_01] Ordinary motor: lower overload threshold below 30 Hz.
// [RULE_02] Variable-frequency motor: same threshold at every speed.
// [RULE_03] Overload coefficient 20.0..120.0 percent scales threshold.
// [RULE_04] Undervoltage selector: 0 off, 1 fault.
// [RULE_05] Compare bus voltage with class-dependent undervoltage level.
// [RULE_06] Overvoltage level sets stall operating voltage.
// [RULE_07] Deceleration voltage coefficient zero disables stall.
// [RULE_08] Current limit 80..200 percent of rated.
// [RULE_09] Vector mode limits only during acceleration.
// [RULE_10] Field weakening converts limit above 50 Hz.
// [RULE_11] Acceleration limiting coefficient zero disables it.
// [RULE_12] Constant-speed coefficient selects automatic or manual reduction.
// [RULE_13] Drop-load level zero disables detection.
// [RULE_14] Drop-load output after current low past time.
// [RULE_15] Pre-alarm level 20..200 percent of rated.
// [RULE_16] Pre-alarm after current high for delay.
// [RULE_17] Pre-alarm shows its warning code on display.
// [RULE_18] Timers restart when condition drops early.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_top
    import dpm_pkg::*;
#(
    parameter int TICK_CYCLES = `DPM_TICK_CYCLES,
    parameter bit HV_CLASS    = 1'b0,
    parameter bit HEAVY_DUTY  = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire dpm_word_t   measCurrent,
    input  wire dpm_word_t   busVoltage,
    input  wire dpm_word_t   outFreq,
    input  wire logic [2:0]  motionPhase,
    input  wire logic        vectorVf,
    output logic             uvFault,
    output logic             ovStall,
    output logic [6:0]       ovStallGain,
    output logic             motorOverload,
    output dpm_word_t        motorOvlThresh,
    output logic             curLimit,
    output dpm_word_t        curLimitLevel,
    output logic [6:0]       accLimitGain,
    output logic             freqReduceAuto,
    output dpm_word_t        freqReduceRate,
    output logic             dropLoad,
    output logic             preAlarm,
    output logic [7:0]       warnCode,
    output logic             irq
);
    localparam dpm_word_t UV_MIN  = HV_CLASS ? `DPM_UV_HV_MIN : `DPM_UV_LV_MIN;
    localparam dpm_word_t UV_MAX  = HV_CLASS ? `DPM_UV_HV_MAX : `DPM_UV_LV_MAX;
    localparam dpm_word_t UV_RST  = HV_CLASS ? `DPM_UV_HV_RST : `DPM_UV_LV_RST;
    localparam dpm_word_t OV_MIN  = HV_CLASS ? `DPM_OV_HV_MIN : `DPM_OV_LV_MIN;
    localparam dpm_word_t OV_MAX  = HV_CLASS ? `DPM_OV_HV_MAX : `DPM_OV_LV_MAX;
    localparam dpm_word_t OV_RST  = HV_CLASS ? `DPM_OV_HV_RST : `DPM_OV_LV_RST;
    localparam dpm_word_t PCT_RST = HEAVY_DUTY ? `DPM_PCT_G_RST : `DPM_PCT_P_RST;

    function automatic dpm_word_t clampW(input logic [31:0] v, input dpm_word_t lo,
                                         input dpm_word_t hi);
        dpm_word_t r;
        r = v[15:0];
        if (v < {16'h0, lo}) begin
            r = lo;
        end else if (v > {16'h0, hi}) begin
            r = hi;
        end
        return r;
    endfunction

    logic [3:0] ctrlReg;
    dpm_word_t  ovlCoefReg;
    dpm_word_t  uvLevelReg;
    dpm_word_t  ovLevelReg;
    dpm_word_t  decVcoefReg;
    dpm_word_t  climLevelReg;
    dpm_word_t  accCcoefReg;
    dpm_word_t  constCcoefReg;
    dpm_word_t  dropTimeReg;
    dpm_word_t  dropLevelReg;
    dpm_word_t  preLevelReg;
    dpm_word_t  preDelayReg;
    dpm_evt_t   irqStatReg;
    dpm_evt_t   irqMaskReg;
    dpm_evt_t   eventPrevReg;
    dpm_evt_t   eventNow;
    dpm_evt_t   eventRise;
    logic       busAccess;
    logic       busWrite;
    logic       addrHit;
    logic [31:0] readMux;
    dpm_word_t  ovlThreshCalc;
    dpm_word_t  climThreshCalc;
    logic       uvNow;
    logic       ovNow;
    logic       ovlNow;
    logic       climEnable;
    logic       climNow;
    dpm_motion_e phase;

    dpm_timer_if dropIf ();
    dpm_timer_if preIf ();

    assign phase     = dpm_motion_e'(motionPhase);
    assign busAccess = psel && penable && !pready;
    assign busWrite  = psel && penable && pready && pwrite;

    // Registers take a write only at the edge where the slave shows ready.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg       <= `DPM_CTRL_RST;
            ovlCoefReg    <= `DPM_OVL_RST;
            uvLevelReg    <= UV_RST;
            ovLevelReg    <= OV_RST;
            decVcoefReg   <= `DPM_COEF_RST;
            climLevelReg  <= PCT_RST;
            accCcoefReg   <= `DPM_COEF_RST;
            constCcoefReg <= `DPM_CONST_RST;
            dropTimeReg   <= `DPM_DROP_T_RST;
            dropLevelReg  <= 16'h0000;
            preLevelReg   <= PCT_RST;
            preDelayReg   <= `DPM_PRE_D_RST;
            irqMaskReg    <= 6'h00;
        end else if (ce && busWrite) begin
            case (paddr)
                `DPM_OFF_CTRL: begin
                    ctrlReg <= (pwdata[1:0] == 2'd3) ? {pwdata[3:2], 2'd2} : pwdata[3:0];
                end
                `DPM_OFF_OVL_COEF: begin
                    ovlCoefReg <= clampW(pwdata, `DPM_OVL_MIN, `DPM_OVL_MAX); // [RULE_03]
                end
                `DPM_OFF_UV_LEVEL: begin
                    uvLevelReg <= clampW(pwdata, UV_MIN, UV_MAX); // [RULE_05]
                end
                `DPM_OFF_OV_LEVEL: begin
                    ovLevelReg <= clampW(pwdata, OV_MIN, OV_MAX); // [RULE_06]
                end
                `DPM_OFF_DEC_VCOEF: begin
                    decVcoefReg <= clampW(pwdata, 16'h0, `DPM_COEF_MAX); // [RULE_07]
                end
                `DPM_OFF_CLIM_LEVEL: begin
                    climLevelReg <= clampW(pwdata, `DPM_CLIM_MIN, `DPM_PCT_MAX); // [RULE_08]
                end
                `DPM_OFF_ACC_CCOEF: begin
                    accCcoefReg <= clampW(pwdata, 16'h0, `DPM_COEF_MAX); // [RULE_11]
                end
                `DPM_OFF_CONST_CCOEF: begin
                    constCcoefReg <= clampW(pwdata, 16'h0, `DPM_CONST_MAX); // [RULE_12]
                end
                `DPM_OFF_DROP_TIME: begin
                    dropTimeReg <= clampW(pwdata, `DPM_DROP_T_MIN, `DPM_DROP_T_MAX); // [RULE_14]
                end
                `DPM_OFF_DROP_LEVEL: begin
                    dropLevelReg <= clampW(pwdata, 16'h0, `DPM_DROP_L_MAX); // [RULE_13]
                end
                `DPM_OFF_PRE_LEVEL: begin
                    preLevelReg <= clampW(pwdata, `DPM_PRE_MIN, `DPM_PCT_MAX); // [RULE_15]
                end
                `DPM_OFF_PRE_DELAY: begin
                    preDelayReg <= clampW(pwdata, 16'h0, `DPM_PRE_D_MAX); // [RULE_16]
                end
                `DPM_OFF_IRQ_MASK: begin
                    irqMaskReg <= pwdata[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        addrHit = 1'b1;
        readMux = 32'h0;
        case (paddr)
            `DPM_OFF_CTRL:        readMux = {28'h0, ctrlReg};
            `DPM_OFF_OVL_COEF:    readMux = {16'h0, ovlCoefReg};
            `DPM_OFF_UV_LEVEL:    readMux = {16'h0, uvLevelReg};
            `DPM_OFF_OV_LEVEL:    readMux = {16'h0, ovLevelReg};
            `DPM_OFF_DEC_VCOEF:   readMux = {16'h0, decVcoefReg};
            `DPM_OFF_CLIM_LEVEL:  readMux = {16'h0, climLevelReg};
            `DPM_OFF_ACC_CCOEF:   readMux = {16'h0, accCcoefReg};
            `DPM_OFF_CONST_CCOEF: readMux = {16'h0, constCcoefReg};
            `DPM_OFF_DROP_TIME:   readMux = {16'h0, dropTimeReg};
            `DPM_OFF_DROP_LEVEL:  readMux = {16'h0, dropLevelReg};
            `DPM_OFF_PRE_LEVEL:   readMux = {16'h0, preLevelReg};
            `DPM_OFF_PRE_DELAY:   readMux = {16'h0, preDelayReg};
            `DPM_OFF_STATUS:      readMux = {26'h0, eventPrevReg};
            `DPM_OFF_IRQ_STAT:    readMux = {26'h0, irqStatReg};
            `DPM_OFF_IRQ_MASK:    readMux = {26'h0, irqMaskReg};
            default:              addrHit = 1'b0;
        endcase
    end

    // One wait state: ready and read data come from flops on the second access cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= busAccess;
            prdata  <= busAccess ? readMux : 32'h0;
            pslverr <= busAccess && !addrHit;
        end
    end

    dpm_lim_calc u_calc (
        .ovlMode    (ctrlReg[`DPM_CTRL_OVL_LSB +: 2]),
        .ovlCoef    (ovlCoefReg),
        .outFreq    (outFreq),
        .climPct    (climLevelReg),
        .fieldWeak  (ctrlReg[`DPM_CTRL_FW_SEL]),
        .ovlThresh  (ovlThreshCalc),
        .climThresh (climThreshCalc)
    );

    assign uvNow  = ctrlReg[`DPM_CTRL_UV_EN] && (busVoltage < uvLevelReg); // [RULE_04] [RULE_05]
    assign ovNow  = (decVcoefReg != 16'h0) && (phase == DPM_ST_DECEL)
                    && (busVoltage >= ovLevelReg); // [RULE_06] [RULE_07]
    assign ovlNow = (ctrlReg[`DPM_CTRL_OVL_LSB +: 2] != 2'd0)
                    && (measCurrent > ovlThreshCalc); // [RULE_03]

    // Vector mode leaves constant speed to the vector limits elsewhere in the drive.
    always_comb begin
        case (phase)
            DPM_ST_ACCEL: climEnable = (accCcoefReg != 16'h0); // [RULE_09] [RULE_11]
            DPM_ST_CONST: climEnable = !vectorVf; // [RULE_09]
            DPM_ST_DECEL: climEnable = 1'b0;
            default:      climEnable = 1'b0;
        endcase
    end
    assign climNow = climEnable && (measCurrent > climThreshCalc); // [RULE_08]

    assign dropIf.cond  = (dropLevelReg != 16'h0) && (measCurrent < dropLevelReg); // [RULE_13]
    assign dropIf.limit = dropTimeReg[11:0];
    assign preIf.cond   = (measCurrent > 16'(preLevelReg * 16'd10)); // [RULE_15]
    assign preIf.limit  = preDelayReg[11:0];

    dpm_qual_timer #(.TICK_CYCLES(TICK_CYCLES)) u_drop (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .tif      (dropIf)
    );

    dpm_qual_timer #(.TICK_CYCLES(TICK_CYCLES)) u_pre (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .ce       (ce),
        .tif      (preIf)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            uvFault        <= 1'b0;
            ovStall        <= 1'b0;
            ovStallGain    <= 7'h00;
            motorOverload  <= 1'b0;
            motorOvlThresh <= 16'h0000;
            curLimit       <= 1'b0;
            curLimitLevel  <= 16'h0000;
            accLimitGain   <= 7'h00;
        end else if (ce) begin
            uvFault        <= uvNow; // [RULE_04]
            ovStall        <= ovNow; // [RULE_07]
            ovStallGain    <= ovNow ? decVcoefReg[6:0] : 7'h00; // [RULE_07]
            motorOverload  <= ovlNow; // [RULE_01] [RULE_02]
            motorOvlThresh <= ovlThreshCalc;
            curLimit       <= climNow; // [RULE_09]
            curLimitLevel  <= climThreshCalc; // [RULE_10]
            accLimitGain   <= (phase == DPM_ST_ACCEL) ? accCcoefReg[6:0] : 7'h00; // [RULE_11]
        end
    end

    // Manual reduction rate is the coefficient itself in hundredths of a hertz per second.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            freqReduceAuto <= 1'b1;
            freqReduceRate <= 16'h0000;
        end else if (ce) begin
            freqReduceAuto <= (constCcoefReg <= `DPM_COEF_MAX); // [RULE_12]
            freqReduceRate <= (constCcoefReg > `DPM_COEF_MAX) ? constCcoefReg : 16'h0; // [RULE_12]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dropLoad <= 1'b0;
            preAlarm <= 1'b0;
            warnCode <= 8'h00;
        end else if (ce) begin
            dropLoad <= dropIf.expired; // [RULE_14]
            preAlarm <= preIf.expired; // [RULE_16]
            warnCode <= preIf.expired ? `DPM_WARN_PRE : 8'h00; // [RULE_17]
        end
    end

    assign eventNow  = {preIf.expired, dropIf.expired, climNow, ovlNow, ovNow, uvNow};
    assign eventRise = eventNow & ~eventPrevReg;

    // A new rising event beats a write-one clear landing in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            eventPrevReg <= 6'h00;
            irqStatReg   <= 6'h00;
            irq          <= 1'b0;
        end else if (ce) begin
            eventPrevReg <= eventNow;
            if (busWrite && paddr == `DPM_OFF_IRQ_STAT) begin
                irqStatReg <= (irqStatReg & ~pwdata[5:0]) | eventRise;
            end else begin
                irqStatReg <= irqStatReg | eventRise;
            end
            irq <= |((irqStatReg | eventRise) & irqMaskReg);
        end
    end
endmodule // dpm_top

// ### test/dpm_stage_model.sv
// Power stage model that presents current, bus voltage, frequency and motion state.
`timescale 1ns/1ps
module dpm_stage_model
    import dpm_pkg::*;
(
    input  logic       core_clk,
    input  logic       arst_n,
    input  dpm_word_t  curSet,
    input  dpm_word_t  busSet,
    input  dpm_word_t  freqSet,
    input  logic [2:0] phaseSet,
    input  logic       vecSet,
    output dpm_word_t  measCurrent,
    output dpm_word_t  busVoltage,
    output dpm_word_t  outFreq,
    output logic [2:0] motionPhase,
    output logic       vectorVf
);
    // One cycle of sample latency, as a real measurement path would add.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {measCurrent, busVoltage, outFreq, motionPhase, vectorVf} <= '0;
        end else begin
            {measCurrent, busVoltage, outFreq, motionPhase, vectorVf} <=
                {curSet, busSet, freqSet, phaseSet, vecSet};
        end
    end
endmodule // dpm_stage_model

// ### test/dpm_top_asserts.sv
// Port-level assertions of the protection monitor.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module dpm_top_asserts
    import dpm_pkg::*;
(
    input logic       core_clk,
    input logic       arst_n,
    input logic       ce,
    input dpm_word_t  measCurrent,
    input dpm_word_t  busVoltage,
    input logic [2:0] motionPhase,
    input logic       vectorVf,
    input logic       uvFault,
    input logic       ovStall,
    input logic [6:0] ovStallGain,
    input logic       motorOverload,
    input dpm_word_t  motorOvlThresh,
    input logic       curLimit,
    input dpm_word_t  curLimitLevel,
    input logic       freqReduceAuto,
    input dpm_word_t  freqReduceRate,
    input logic       preAlarm,
    input logic [7:0] warnCode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    chk_warn_code: assert property (warnCode == (preAlarm ? 8'h09 : 8'h00))
        else $error("warning code does not follow pre-alarm");
    chk_ovl_cmp: assert property ($past(ce) && motorOverload |->
        $past(measCurrent) > motorOvlThresh) else $error("overload without excess current");
    chk_clim_cmp: assert property ($past(ce) && curLimit |->
        $past(measCurrent) > curLimitLevel) else $error("limit without excess current");
    chk_clim_decel: assert property ($past(ce) && $past(motionPhase) == DPM_ST_DECEL
        |-> !curLimit) else $error("current limited in deceleration");
    chk_clim_vector: assert property ($past(ce) && $past(vectorVf)
        && $past(motionPhase) == DPM_ST_CONST |-> !curLimit) else $error("vector limit at speed");
    chk_stall_cause: assert property ($past(ce) && ovStall |->
        $past(motionPhase) == DPM_ST_DECEL && ovStallGain != 7'h00
        && $past(busVoltage) >= `DPM_OV_LV_MIN) else $error("stall without its cause");
    chk_freq_mode: assert property (freqReduceAuto ? freqReduceRate == 16'h0000
        : freqReduceRate > 16'h0064) else $error("reduction mode and rate disagree");
    chk_uv_level: assert property ($past(ce) && uvFault |->
        $past(busVoltage) < `DPM_UV_LV_MAX) else $error("undervoltage above level range");
endmodule // dpm_top_asserts
bind dpm_top dpm_top_asserts chk (.*);

// ### test/tb.sv
// Self-checking bench of the protection monitor.
`timescale 1ns/1ps
`include "dpm_consts.svh"
module tb;
    import dpm_pkg::*;
    localparam int TK = 10;
    logic core_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, vecSet = 1'b0, pready, pslverr, uvFault, ovStall, motorOverload;
    logic curLimit, freqReduceAuto, dropLoad, preAlarm, irq, vectorVf;
    logic [7:0] paddr = 8'h00, warnCode;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] phaseSet = 3'h0, motionPhase;
    logic [6:0] ovStallGain, accLimitGain;
    dpm_word_t curSet = '0, busSet = '0, freqSet = '0, measCurrent, busVoltage, outFreq;
    dpm_word_t motorOvlThresh, curLimitLevel, freqReduceRate;
    logic [33:0] expQ[$];
    logic [33:0] e;
    int n_errors = 0, cmp_count = 0, n, rs;
    dpm_top #(.TICK_CYCLES(TK)) dut (.*);
    dpm_stage_model model (.*);
    always #2.5 core_clk = ~core_clk;
    task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] ex, logic er);
        expQ.push_back({~w, er, ex});
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] ex);
        apb(1'b0, a, 32'h0, ex, 1'b0);
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic drv(dpm_word_t c, dpm_word_t b, dpm_word_t f, logic [2:0] p, logic v);
        @(posedge core_clk);
        curSet <= c;
        busSet <= b;
        freqSet <= f;
        phaseSet <= p;
        vecSet <= v;
        settle();
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (psel && penable && pready) begin
            if (expQ.size() == 0) chk("answer", 32'h0, 32'h1);
            else begin
                e = expQ.pop_front();
                chk("pslverr", 32'(e[32]), 32'(pslverr));
                if (e[33]) chk("prdata", e[31:0], prdata);
            end
        end
    end
    // The whole sequence needs about a thousand cycles; twenty times that means a hang.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
    initial begin
        rs = $urandom(8471);
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(`DPM_OFF_CTRL, 32'h1);
        rd(`DPM_OFF_UV_LEVEL, 32'hc8);
        rd(`DPM_OFF_CLIM_LEVEL, 32'ha0);
        rd(`DPM_OFF_CONST_CCOEF, 32'h28);
        apb(1'b0, 8'h3c, 32'h0, 32'h0, 1'b1);
        wr(`DPM_OFF_OVL_COEF, 32'h5);
        rd(`DPM_OFF_OVL_COEF, 32'hc8);
        wr(`DPM_OFF_OVL_COEF, 32'h7d0);
        rd(`DPM_OFF_OVL_COEF, 32'h4b0);
        rs = 181 + $urandom % 19;
        drv(16'h0, 16'(rs), 16'h0, 3'h0, 1'b0);
        chk("uvFault", 32'h0, 32'(uvFault));
        wr(`DPM_OFF_CTRL, 32'h5);
        wr(`DPM_OFF_IRQ_MASK, 32'h1);
        settle();
        chk("uvFault", 32'h1, 32'(uvFault));
        chk("irq", 32'h1, 32'(irq));
        rd(`DPM_OFF_IRQ_STAT, 32'h1);
        drv(16'h0, 16'hc8, 16'h0, 3'h0, 1'b0);
        chk("uvFault", 32'h0, 32'(uvFault));
        wr(`DPM_OFF_IRQ_STAT, 32'h1);
        settle();
        chk("irq", 32'h0, 32'(irq));
        wr(`DPM_OFF_CTRL, 32'h1);
        settle();
        chk("motorOvlThresh", 32'h258, 32'(motorOvlThresh));
        drv(16'h4b1, 16'hc8, 16'h1770, 3'h0, 1'b0);
        chk("motorOvlThresh", 32'h4b0, 32'(motorOvlThresh));
        chk("motorOverload", 32'h1, 32'(motorOverload));
        wr(`DPM_OFF_CTRL, 32'h0);
        settle();
        chk("motorOverload", 32'h0, 32'(motorOverload));
        wr(`DPM_OFF_CTRL, 32'hb);
        rd(`DPM_OFF_CTRL, 32'ha);
        drv(16'h4b1, 16'hc8, 16'h0, 3'h0, 1'b0);
        chk("motorOvlThresh", 32'h4b0, 32'(motorOvlThresh));
        rs = 1601 + $urandom % 300;
        drv(16'(rs), 16'hc8, 16'hfa0, DPM_ST_ACCEL, 1'b0);
        chk("curLimitLevel", 32'h640, 32'(curLimitLevel));
        chk("curLimit", 32'h1, 32'(curLimit));
        chk("accLimitGain", 32'h32, 32'(accLimitGain));
        drv(16'(rs), 16'hc8, 16'hfa0, DPM_ST_CONST, 1'b0);
        chk("curLimit", 32'h1, 32'(curLimit));
        drv(16'(rs), 16'hc8, 16'hfa0, DPM_ST_CONST, 1'b1);
        chk("curLimit", 32'h0, 32'(curLimit));
        drv(16'(rs), 16'hc8, 16'h2710, DPM_ST_ACCEL, 1'b0);
        chk("curLimitLevel", 32'h320, 32'(curLimitLevel));
        wr(`DPM_OFF_ACC_CCOEF, 32'h0);
        settle();
        chk("curLimit", 32'h0, 32'(curLimit));
        drv(16'h0, 16'h172, 16'h3e8, DPM_ST_DECEL, 1'b0);
        chk("ovStall", 32'h1, 32'(ovStall));
        chk("ovStallGain", 32'h32, 32'(ovStallGain));
        drv(16'h0, 16'h171, 16'h3e8, DPM_ST_DECEL, 1'b0);
        chk("ovStall", 32'h0, 32'(ovStall));
        wr(`DPM_OFF_DEC_VCOEF, 32'h0);
        drv(16'h0, 16'h17c, 16'h3e8, DPM_ST_DECEL, 1'b0);
        chk("ovStall", 32'h0, 32'(ovStall));
        wr(`DPM_OFF_CONST_CCOEF, 32'h65);
        settle();
        chk("freqReduceRate", 32'h65, 32'(freqReduceRate));
        wr(`DPM_OFF_CONST_CCOEF, 32'h64);
        settle();
        chk("freqReduceAuto", 32'h1, 32'(freqReduceAuto));
        repeat (120) settle();
        chk("dropLoad", 32'h0, 32'(dropLoad));
        drv(16'h1f4, 16'hc8, 16'h0, 3'h0, 1'b0);
        wr(`DPM_OFF_DROP_LEVEL, 32'h64);
        wr(`DPM_OFF_DROP_TIME, 32'h3);
        drv(16'h32, 16'hc8, 16'h0, 3'h0, 1'b0);
        repeat (4) settle();
        drv(16'h1f4, 16'hc8, 16'h0, 3'h0, 1'b0);
        drv(16'h32, 16'hc8, 16'h0, 3'h0, 1'b0);
        repeat (4) settle();
        chk("dropLoad", 32'h0, 32'(dropLoad));
        repeat (4) settle();
        chk("dropLoad", 32'h1, 32'(dropLoad));
        wr(`DPM_OFF_PRE_LEVEL, 32'h14);
        wr(`DPM_OFF_PRE_DELAY, 32'h2);
        @(posedge core_clk);
        curSet <= 16'hfa;
        for (n = 0; n < 100 && preAlarm !== 1'b1; n++) @(negedge core_clk);
        chk("preDelay", 32'h1, 32'(n > 18 && n < 27));
        chk("warnCode", 32'h9, 32'(warnCode));
        drv(16'h0, 16'hc8, 16'h0, 3'h0, 1'b0);
        chk("warnCode", 32'h0, 32'(warnCode));
        test_done();
    end
endmodule // tb
